// ### hw/synth_core.sv
// synthesizer digital section: serial load, latches, dividers, phase detector, lock
//
// Contract
// RQ1 - shift serial data into a 24-bit register on each serial clock rise
// RQ2 - host sends msb first so select bits land lowest
// RQ3 - load strobe rise copies the word into exactly one latch
// RQ4 - select 00 ref, 01 feedback, 10 function, 11 start-up latch
// RQ5 - 14-bit reference divider, ratios 1 to 16383
// RQ6 - feedback ratio is main count times P plus swallow count
// RQ7 - prescaler modulus selectable 8/9, 16/17, 32/33 or 64/65
// RQ8 - main counter 13 bits, values 3 to 8191
// RQ9 - swallow counter 6 bits, values 0 to 63
// RQ10 - host keeps ratio at least P squared minus P
// RQ11 - host keeps prescaler output at or below 325 MHz
// RQ12 - two-bit field sets antibacklash pulse width
// RQ13 - three-bit field selects what appears on the monitor output
// RQ14 - digital lock after three good cycles when precision bit is 0
// RQ15 - digital lock after five good cycles when precision bit is 1
// RQ16 - lock stays until a cycle shows error over 25 ns
// RQ17 - analog lock is open-drain, high with narrow low pulses
// RQ18 - chip enable low powers down and three-states the pump
// RQ19 - reference latch field layout
// RQ20 - feedback latch field layout
// RQ21 - function and start-up latch field layout
// RQ22 - divide by P+1 until swallow expires, then P until main expires
`timescale 1ns/100ps
`default_nettype none
`include "synth_defs.svh"

module synth_core (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic i_load_strobe,
  input wire logic i_chip_enable,
  input wire logic i_ref_input,
  input wire logic i_rf_input,
  output logic o_pump_up,
  output logic o_pump_down,
  output logic o_pump_enable,
  output logic [2:0] o_pump_current,
  output logic o_lock,
  output logic o_powered,
  output logic o_monitor_out,
  output logic o_monitor_oe
);

  localparam int NPIN = 6;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_CE = 3;
  localparam int PIN_REF = 4;
  localparam int PIN_RF = 5;
  localparam int LOCK_SET_CYC = `LOCK_SET_CYC_INT;
  localparam int LOCK_CLEAR_CYC = `LOCK_CLEAR_CYC_INT;

  // ---------------- pin synchronisers ----------------
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_prev;
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_rise;

  assign pin_raw = {i_rf_input, i_ref_input, i_chip_enable, i_load_strobe,
                    i_serial_data, i_serial_clk};

  // two flops per pin; only the second flop and its delayed copy feed logic
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_prev;

  // ---------------- serial shift register ----------------
  logic [23:0] shift_word;

  // data and clock share the same sync delay, so data is sampled at the clock edge
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_word <= `LATCH_RST;
    end else if (pin_rise[PIN_SCLK]) begin
      shift_word <= {shift_word[22:0], pin_sync[PIN_SDATA]}; // see RQ1, see RQ2
    end
  end

  // ---------------- latch decode ----------------
  synth_pkg::ref_latch_s ref_latch;
  synth_pkg::fb_latch_s fb_latch;
  synth_pkg::func_latch_s func_latch;
  logic init_clear;
  wire [1:0] word_sel;
  wire load_ref;
  wire load_fb;
  wire load_func;
  wire load_init;

  assign word_sel = shift_word[1:0];
  assign load_ref = pin_rise[PIN_LOAD] & (word_sel == `LSEL_REF); // see RQ3, see RQ4
  assign load_fb = pin_rise[PIN_LOAD] & (word_sel == `LSEL_FB); // see RQ4
  assign load_func = pin_rise[PIN_LOAD] & (word_sel == `LSEL_FUNC); // see RQ4
  assign load_init = pin_rise[PIN_LOAD] & (word_sel == `LSEL_INIT); // see RQ4

  // the start-up word fills the function latch and clears the counters once
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_latch <= `LATCH_RST;
      fb_latch <= `LATCH_RST;
      func_latch <= `LATCH_RST;
      init_clear <= 1'b0;
    end else begin
      init_clear <= load_init;
      if (load_ref) begin
        ref_latch <= shift_word; // see RQ19
      end
      if (load_fb) begin
        fb_latch <= shift_word; // see RQ20
      end
      if (load_func | load_init) begin
        func_latch <= shift_word; // see RQ21
      end
    end
  end

  // ---------------- power and counter clear ----------------
  wire powered;
  wire counter_clear;

  // chip enable low forces power-down whatever the software bit says
  assign powered = pin_sync[PIN_CE] & ~func_latch.sleep_bit_one; // see RQ18
  assign counter_clear = ~powered | func_latch.divider_clear | init_clear;

  // ---------------- reference divider ----------------
  wire ref_term;
  logic ref_tick;

  synth_divider #(
    .W(14)
  ) u_ref_div (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(counter_clear),
    .i_tick(pin_rise[PIN_REF]),
    .i_ratio(ref_latch.ref_div_ratio),
    .o_terminal(ref_term)
  ); // see RQ5

  // ---------------- feedback divider ----------------
  logic [5:0] swallow_left;
  logic [6:0] base_modulus;
  wire [6:0] presc_ratio;
  wire presc_tick;
  wire fb_tick;

  // base modulus P from the select field
  always_comb begin
    unique case (func_latch.modulus_sel)
      `MODSEL_8: base_modulus = `PRESC_8;
      `MODSEL_16: base_modulus = `PRESC_16;
      `MODSEL_32: base_modulus = `PRESC_32;
      `MODSEL_64: base_modulus = `PRESC_64;
    endcase
  end // see RQ7

  // dual modulus: P+1 while swallows remain, else P
  assign presc_ratio = (swallow_left != 6'h00) ? base_modulus + `PRESC_ONE
                                               : base_modulus; // see RQ22

  synth_divider #(
    .W(7)
  ) u_prescaler (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(counter_clear),
    .i_tick(pin_rise[PIN_RF]),
    .i_ratio(presc_ratio),
    .o_terminal(presc_tick)
  );

  synth_divider #(
    .W(13)
  ) u_main_div (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(counter_clear),
    .i_tick(presc_tick),
    .i_ratio(fb_latch.main_count),
    .o_terminal(fb_tick)
  ); // see RQ8, see RQ6

  // swallow counter reloads when the main counter expires
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      swallow_left <= 6'h00;
    end else if (counter_clear | fb_tick) begin
      swallow_left <= fb_latch.swallow_count; // see RQ9, see RQ22
    end else if (presc_tick && swallow_left != 6'h00) begin
      swallow_left <= swallow_left - 6'h01;
    end
  end

  // ---------------- phase detector ----------------
  synth_pkg::pfd_state_e pfd_state;
  synth_pkg::pfd_state_e next_pfd_state;
  logic [`ERR_W-1:0] err_count;
  logic [1:0] abp_left;
  logic eval;
  logic [`ERR_W-1:0] eval_err;
  logic next_eval;
  wire abp_done;

  assign abp_done = (abp_left == `ABP_ZERO);

  // first edge opens a pulse, second closes it into the antibacklash overlap
  always_comb begin
    next_pfd_state = pfd_state;
    next_eval = 1'b0;
    unique case (pfd_state)
      synth_pkg::PFD_IDLE: begin
        if (ref_tick & fb_tick) begin
          next_pfd_state = synth_pkg::PFD_BOTH;
          next_eval = 1'b1;
        end else if (ref_tick) begin
          next_pfd_state = synth_pkg::PFD_UP;
        end else if (fb_tick) begin
          next_pfd_state = synth_pkg::PFD_DOWN;
        end
      end
      synth_pkg::PFD_UP: begin
        if (fb_tick) begin
          next_pfd_state = synth_pkg::PFD_BOTH;
          next_eval = 1'b1;
        end
      end
      synth_pkg::PFD_DOWN: begin
        if (ref_tick) begin
          next_pfd_state = synth_pkg::PFD_BOTH;
          next_eval = 1'b1;
        end
      end
      synth_pkg::PFD_BOTH: begin
        if (abp_done) begin
          next_pfd_state = synth_pkg::PFD_IDLE;
        end
      end
    endcase
  end

  // edges that land inside the overlap are dropped; the overlap is short
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pfd_state <= synth_pkg::PFD_IDLE;
    end else if (counter_clear) begin
      pfd_state <= synth_pkg::PFD_IDLE;
    end else begin
      pfd_state <= next_pfd_state;
    end
  end

  // antibacklash overlap lasts width field plus one cycle
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      abp_left <= `ABP_ZERO;
    end else if (next_eval) begin
      abp_left <= ref_latch.pulse_width_sel; // see RQ12
    end else if (pfd_state == synth_pkg::PFD_BOTH && !abp_done) begin
      abp_left <= abp_left - `ABP_ONE;
    end
  end

  // phase error is the number of cycles one pulse ran alone
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      err_count <= `ERR_ZERO;
      eval <= 1'b0;
      eval_err <= `ERR_ZERO;
    end else begin
      eval <= next_eval & ~counter_clear;
      if (next_eval) begin
        eval_err <= (pfd_state == synth_pkg::PFD_IDLE) ? `ERR_ZERO : err_count;
      end
      if (pfd_state == synth_pkg::PFD_IDLE) begin
        err_count <= `ERR_ONE; // one lone cycle already counts as one cycle of error
      end else if (err_count != `ERR_MAX && pfd_state != synth_pkg::PFD_BOTH) begin
        err_count <= err_count + `ERR_ONE;
      end
    end
  end

  // ---------------- digital lock detect ----------------
  logic [2:0] lock_run;
  logic lock;
  wire [2:0] lock_target;
  wire err_good;
  wire err_bad;

  assign lock_target = ref_latch.lock_precision ? `LOCK_COUNT_PREC
                                                : `LOCK_COUNT_STD; // see RQ14, see RQ15
  assign err_good = (32'(eval_err) < LOCK_SET_CYC);
  assign err_bad = (32'(eval_err) >= LOCK_CLEAR_CYC);

  // at 40 ns resolution both thresholds meet at one cycle of error
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lock_run <= `LOCK_RUN_ZERO;
      lock <= 1'b0;
    end else if (counter_clear) begin
      lock_run <= `LOCK_RUN_ZERO;
      lock <= 1'b0;
    end else if (eval) begin
      if (err_bad) begin
        lock_run <= `LOCK_RUN_ZERO;
        lock <= 1'b0; // see RQ16
      end else if (err_good) begin
        if (lock_run != lock_target) begin
          lock_run <= lock_run + `LOCK_RUN_STEP;
        end
        if (lock_run + `LOCK_RUN_STEP >= lock_target) begin
          lock <= 1'b1; // see RQ14, see RQ15
        end
      end else begin
        lock_run <= `LOCK_RUN_ZERO;
      end
    end
  end

  // ---------------- charge pump drive ----------------
  synth_pkg::pump_s pump;
  wire raw_up;
  wire raw_down;

  assign raw_up = (pfd_state == synth_pkg::PFD_UP) | (pfd_state == synth_pkg::PFD_BOTH);
  assign raw_down = (pfd_state == synth_pkg::PFD_DOWN) | (pfd_state == synth_pkg::PFD_BOTH);
  assign pump.enable = powered & ~func_latch.pump_tristate; // see RQ18
  // polarity swaps the pump directions for an inverting loop filter
  assign pump.up = pump.enable & (func_latch.detector_polarity ? raw_up : raw_down);
  assign pump.down = pump.enable & (func_latch.detector_polarity ? raw_down : raw_up);
  assign pump.current = fb_latch.pump_gain_sel ? func_latch.pump_current_two
                                               : func_latch.pump_current_one;

  // ---------------- monitor output ----------------
  logic ref_half;
  logic fb_half;
  logic next_mon_out;
  logic next_mon_oe;

  // scaled clocks are square waves toggled on each divider terminal
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_half <= 1'b0;
      fb_half <= 1'b0;
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= ref_term & ~counter_clear; // extra stage matches the two-stage feedback chain
      ref_half <= ref_half ^ ref_tick;
      fb_half <= fb_half ^ fb_tick;
    end
  end

  // analog lock pulls low only while a pump pulse is active
  always_comb begin
    next_mon_out = 1'b0;
    next_mon_oe = 1'b1;
    unique case (func_latch.out_mux_sel)
      `MUX_TRISTATE: next_mon_oe = 1'b0;
      `MUX_DLOCK: next_mon_out = lock;
      `MUX_NDIV: next_mon_out = fb_half;
      `MUX_HIGH: next_mon_out = 1'b1;
      `MUX_RDIV: next_mon_out = ref_half;
      `MUX_ALOCK: next_mon_oe = raw_up | raw_down; // see RQ17
      `MUX_SDATA: next_mon_out = shift_word[23];
      `MUX_LOW: next_mon_out = 1'b0;
    endcase
  end // see RQ13

  // ---------------- registered outputs ----------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pump_up <= 1'b0;
      o_pump_down <= 1'b0;
      o_pump_enable <= 1'b0;
      o_pump_current <= 3'h0;
      o_lock <= 1'b0;
      o_powered <= 1'b0;
      o_monitor_out <= 1'b0;
      o_monitor_oe <= 1'b0;
    end else begin
      o_pump_up <= pump.up;
      o_pump_down <= pump.down;
      o_pump_enable <= pump.enable;
      o_pump_current <= pump.current;
      o_lock <= lock;
      o_powered <= powered;
      o_monitor_out <= next_mon_out;
      o_monitor_oe <= next_mon_oe;
    end
  end

endmodule : synth_core

`default_nettype wire

// ### hw/synth_defs.svh
// named constants for the synthesizer serial load, dividers and lock detect
`ifndef SYNTH_DEFS_SVH
`define SYNTH_DEFS_SVH

// latch select codes in the two lowest bits of each word
`define LSEL_REF 2'h0
`define LSEL_FB 2'h1
`define LSEL_FUNC 2'h2
`define LSEL_INIT 2'h3

// reset value of every latch
`define LATCH_RST 24'h000000

// prescaler modulus select codes and the base modulus P
`define MODSEL_8 2'h0
`define MODSEL_16 2'h1
`define MODSEL_32 2'h2
`define MODSEL_64 2'h3
`define PRESC_8 7'h08
`define PRESC_16 7'h10
`define PRESC_32 7'h20
`define PRESC_64 7'h40
`define PRESC_ONE 7'h01

// monitor output select codes
`define MUX_TRISTATE 3'h0
`define MUX_DLOCK 3'h1
`define MUX_NDIV 3'h2
`define MUX_HIGH 3'h3
`define MUX_RDIV 3'h4
`define MUX_ALOCK 3'h5
`define MUX_SDATA 3'h6
`define MUX_LOW 3'h7

// consecutive good phase detector cycles needed for lock
`define LOCK_COUNT_STD 3'h3
`define LOCK_COUNT_PREC 3'h5
`define LOCK_RUN_ZERO 3'h0
`define LOCK_RUN_STEP 3'h1

// timing: core clock period and lock thresholds in ns
`define CORE_CLK_PERIOD_NS 40
`define LOCK_SET_NS 15
`define LOCK_CLEAR_NS 25
// longest time: round down, at least one cycle
`define LOCK_SET_CYC_INT \
  (((`LOCK_SET_NS / `CORE_CLK_PERIOD_NS) < 1) ? 1 : (`LOCK_SET_NS / `CORE_CLK_PERIOD_NS))
// least time: round up, at least one cycle
`define LOCK_CLEAR_CYC_INT \
  ((`LOCK_CLEAR_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

// phase error counter width and antibacklash base width in cycles
`define ERR_W 8
`define ERR_ZERO 8'h00
`define ERR_ONE 8'h01
`define ERR_MAX 8'hff
`define ABP_ZERO 2'h0
`define ABP_ONE 2'h1

`endif

// ### hw/synth_pkg.sv
// types shared by the synthesizer digital section
package synth_pkg;

  // reference divider latch image
  typedef struct packed {
    logic ignored;
    logic [1:0] zero_bits;
    logic lock_precision;
    logic [1:0] test_mode_bits;
    logic [1:0] pulse_width_sel;
    logic [13:0] ref_div_ratio;
    logic [1:0] latch_select_bits;
  } ref_latch_s;

  // feedback divider latch image
  typedef struct packed {
    logic [1:0] spare;
    logic pump_gain_sel;
    logic [12:0] main_count;
    logic [5:0] swallow_count;
    logic [1:0] latch_select_bits;
  } fb_latch_s;

  // function and start-up latch image
  typedef struct packed {
    logic [1:0] modulus_sel;
    logic sleep_bit_two;
    logic [2:0] pump_current_two;
    logic [2:0] pump_current_one;
    logic [3:0] fastlock_timeout;
    logic fastlock_select;
    logic fastlock_enable;
    logic pump_tristate;
    logic detector_polarity;
    logic [2:0] out_mux_sel;
    logic sleep_bit_one;
    logic divider_clear;
    logic [1:0] latch_select_bits;
  } func_latch_s;

  // charge pump drive carrier
  typedef struct packed {
    logic up;
    logic down;
    logic enable;
    logic [2:0] current;
  } pump_s;

  // phase detector states
  typedef enum logic [3:0] {
    PFD_IDLE = 4'b0001,
    PFD_UP = 4'b0010,
    PFD_DOWN = 4'b0100,
    PFD_BOTH = 4'b1000
  } pfd_state_e;

endpackage : synth_pkg

// ### hw/synth_divider.sv
// programmable tick divider: one terminal pulse every ratio input ticks
`timescale 1ns/100ps
`default_nettype none

module synth_divider #(
  parameter int W = 14
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [W-1:0] i_ratio,
  output logic o_terminal
);

  logic [W-1:0] count;
  wire [W-1:0] ratio_m1;
  wire at_end;

  // a ratio of zero behaves as one so the divider never stalls
  assign ratio_m1 = (i_ratio == '0) ? '0 : i_ratio - W'(1);
  assign at_end = (count == '0);

  // count down, reload on the last tick
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= '0;
      o_terminal <= 1'b0;
    end else if (i_clear) begin
      count <= ratio_m1;
      o_terminal <= 1'b0;
    end else begin
      o_terminal <= i_tick & at_end;
      if (i_tick) begin
        count <= at_end ? ratio_m1 : count - W'(1);
      end
    end
  end

endmodule : synth_divider

`default_nettype wire

// ### verification/synth_core_chk.sv
// assertion checker for the synthesizer core pins
`timescale 1ns/100ps
`default_nettype none

module synth_core_chk (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic i_load_strobe,
  input wire logic i_chip_enable,
  input wire logic o_pump_up,
  input wire logic o_pump_down,
  input wire logic o_pump_enable,
  input wire logic o_lock,
  input wire logic o_powered,
  input wire logic o_monitor_out,
  input wire logic o_monitor_oe
);
  logic sclk_q;
  logic strb_q;
  logic [23:0] shadow;
  logic [2:0] mux_sel;
  logic [3:0] quiet;
  logic [3:0] off_cnt;
  logic [7:0] err_age;
  wire sclk_rise = i_serial_clk && !sclk_q;
  wire strb_rise = i_load_strobe && !strb_q;
  wire one_side = o_pump_up ^ o_pump_down;
  wire settled = (quiet == 4'hf) && o_powered;

  // pin-level shadow of the shift register and monitor select; counters saturate
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
      strb_q <= 1'b0;
      shadow <= 24'h000000;
      mux_sel <= 3'h0;
      quiet <= 4'h0;
      off_cnt <= 4'h0;
      err_age <= 8'hff;
    end else begin
      sclk_q <= i_serial_clk;
      strb_q <= i_load_strobe;
      shadow <= sclk_rise ? {shadow[22:0], i_serial_data} : shadow;
      mux_sel <= (strb_rise && shadow[1]) ? shadow[6:4] : mux_sel;
      quiet <= (sclk_rise || strb_rise) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
      off_cnt <= i_chip_enable ? 4'h0 : ((off_cnt == 4'hf) ? off_cnt : off_cnt + 4'h1);
      err_age <= one_side ? 8'h00 : ((err_age == 8'hff) ? err_age : err_age + 8'h01);
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_rst_quiet;
    $fell(i_sys_rst) |-> !o_lock && !o_powered && !o_pump_enable && !o_monitor_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  property p_ce_off;
    off_cnt >= 4'h8 |-> !o_powered && !o_pump_enable;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("powered with chip enable low");
  property p_abp_width;
    (o_pump_up && o_pump_down) [*4] |=> !(o_pump_up && o_pump_down);
  endproperty
  a_abp_width: assert property (p_abp_width) else $error("overlap pulse too wide");
  property p_lock_set;
    $rose(o_lock) |-> err_age >= 8'h03;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock set too soon after error");
  property p_lock_hold;
    $fell(o_lock) && $past(o_powered) && o_powered |-> err_age <= 8'h06;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped with no error");
  property p_mux_fixed;
    settled && (mux_sel == 3'h0 || mux_sel == 3'h3 || mux_sel == 3'h7) |->
      o_monitor_oe == (mux_sel != 3'h0) && (mux_sel == 3'h0 || o_monitor_out == (mux_sel == 3'h3));
  endproperty
  a_mux_fixed: assert property (p_mux_fixed) else $error("fixed monitor level wrong");
  property p_mux_shift;
    settled && mux_sel == 3'h6 |-> o_monitor_oe && o_monitor_out == shadow[23];
  endproperty
  a_mux_shift: assert property (p_mux_shift) else $error("monitor shift bit wrong");
  property p_mux_lock;
    settled && mux_sel == 3'h1 && $stable(o_lock) |-> o_monitor_oe && o_monitor_out == o_lock;
  endproperty
  a_mux_lock: assert property (p_mux_lock) else $error("monitor lock copy wrong");
  property p_mux_alock;
    settled && mux_sel == 3'h5 && o_pump_enable |->
      !o_monitor_out && o_monitor_oe == (o_pump_up || o_pump_down);
  endproperty
  a_mux_alock: assert property (p_mux_alock) else $error("analog lock drive wrong");
endmodule : synth_core_chk

bind synth_core synth_core_chk chk (
  .i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst),
  .i_serial_clk(i_serial_clk),
  .i_serial_data(i_serial_data),
  .i_load_strobe(i_load_strobe),
  .i_chip_enable(i_chip_enable),
  .o_pump_up(o_pump_up),
  .o_pump_down(o_pump_down),
  .o_pump_enable(o_pump_enable),
  .o_lock(o_lock),
  .o_powered(o_powered),
  .o_monitor_out(o_monitor_out),
  .o_monitor_oe(o_monitor_oe)
);

`default_nettype wire

// ### verification/host_serial_model.sv
// host controller model driving the three-wire load link
`timescale 1ns/100ps
`default_nettype none

module host_serial_model (
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic [23:0] i_word,
  output logic o_busy,
  output logic o_serial_clk,
  output logic o_serial_data,
  output logic o_load_strobe
);
  logic go_seen;
  logic [23:0] word;

  // each phase lasts three core cycles, above the two-cycle minimum
  initial begin
    o_busy = 1'b0;
    o_serial_clk = 1'b0;
    o_serial_data = 1'b0;
    o_load_strobe = 1'b0;
    forever begin
      @(posedge i_core_clk);
      go_seen = i_go;
      word = i_word;
      @(negedge i_core_clk);
      if (!go_seen) begin
        o_serial_data = ~o_serial_data; // idle data carries no meaning, so keep it moving
      end else begin
        o_busy = 1'b1;
        for (int b = 23; b >= 0; b--) begin
          o_serial_data = word[b];
          repeat (3) @(negedge i_core_clk);
          o_serial_clk = 1'b1;
          repeat (3) @(negedge i_core_clk);
          o_serial_clk = 1'b0;
        end
        repeat (3) @(negedge i_core_clk);
        o_load_strobe = 1'b1;
        repeat (3) @(negedge i_core_clk);
        o_load_strobe = 1'b0;
        repeat (3) @(negedge i_core_clk);
        o_busy = 1'b0;
      end
    end
  end
endmodule : host_serial_model

`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the synthesizer core
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  typedef struct packed {
    logic [23:0] word;
    logic oe;
    logic out;
  } row_s;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ce = 1'b1;
  logic ref_in = 1'b0;
  logic rf_in = 1'b0;
  logic go = 1'b0;
  logic [23:0] word = 24'h000000;
  logic busy, sclk, sdata, strobe, up, down, pen, lock, powered, mon, mon_oe;
  logic [2:0] cur;
  row_s rows [8];
  int errors = 0;
  int comparisons = 0;

  host_serial_model host (.i_core_clk(i_core_clk), .i_go(go), .i_word(word), .o_busy(busy),
    .o_serial_clk(sclk), .o_serial_data(sdata), .o_load_strobe(strobe));
  synth_core uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_serial_clk(sclk),
    .i_serial_data(sdata), .i_load_strobe(strobe), .i_chip_enable(ce), .i_ref_input(ref_in),
    .i_rf_input(rf_in), .o_pump_up(up), .o_pump_down(down), .o_pump_enable(pen),
    .o_pump_current(cur), .o_lock(lock), .o_powered(powered), .o_monitor_out(mon),
    .o_monitor_oe(mon_oe));

  always #20 i_core_clk = ~i_core_clk;
  // same waveform on both inputs, so equal ratios give zero phase error
  always @(negedge i_core_clk) begin
    ref_in <= ~ref_in;
    rf_in <= ~rf_in;
  end

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 400) begin
      @(negedge i_core_clk);
      k++;
    end
    if (k == 400) begin
      errors++;
      $display("wrong value at %0t: host model hang", $time);
      wrap_up();
    end
  endtask : wait_busy

  task automatic send(input logic [23:0] w);
    word <= w;
    go <= 1'b1;
    @(negedge i_core_clk);
    wait_busy(1'b1);
    go <= 1'b0;
    wait_busy(1'b0);
  endtask : send

  // function or start-up word; currents 5 and 2 tell the gain select apart
  function automatic logic [23:0] fwd(input logic [1:0] sel, input logic [2:0] mux,
      input logic [1:0] msel);
    synth_pkg::func_latch_s f;
    f = 24'h000000;
    f.modulus_sel = msel;
    f.pump_current_one = 3'h5;
    f.pump_current_two = 3'h2;
    f.detector_polarity = 1'b1;
    f.out_mux_sel = mux;
    f.latch_select_bits = sel;
    return f;
  endfunction : fwd

  // reference word: ratio 56 matches N = 7 * 8 + 0, the smallest contiguous ratio for P = 8
  function automatic logic [23:0] rwd(input logic prec, input logic [1:0] abp);
    return {3'h0, prec, 2'h0, abp, 14'h0038, 2'h0};
  endfunction : rwd

  task automatic at(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : at

  initial begin
    rows[0] = {fwd(2'h2, 3'h3, 2'h0), 2'b11};
    rows[1] = {fwd(2'h3, 3'h7, 2'h0), 2'b10};
    rows[2] = {fwd(2'h2, 3'h0, 2'h0), 2'b00};
    rows[3] = {24'h000070, 2'b00};
    rows[4] = {fwd(2'h2, 3'h6, 2'h2), 2'b11};
    rows[5] = {fwd(2'h3, 3'h6, 2'h1), 2'b10};
    rows[6] = {24'h800701, 2'b11};
    rows[7] = {fwd(2'h2, 3'h3, 2'h0), 2'b11};
    at(16);
    i_sys_rst <= 1'b0;
    at(4);
    check({2'h0, mon_oe}, 3'h0, "monitor enable after reset");
    check({2'h0, lock}, 3'h0, "lock after reset");
    $display("test reset done");
    ce <= 1'b0;
    at(10);
    check({1'h0, powered, pen}, 3'h0, "power with chip enable low");
    ce <= 1'b1;
    at(10);
    check({2'h0, powered}, 3'h1, "power with chip enable high");
    $display("test chip enable done");
    // rows: the word loaded and the monitor level it should give
    foreach (rows[i]) begin
      send(rows[i].word);
      at(16);
      check({2'h0, mon_oe}, {2'h0, rows[i].oe}, "monitor enable");
      if (rows[i].oe) begin
        check({2'h0, mon}, {2'h0, rows[i].out}, "monitor level");
      end
      $display("test row %0d done", i);
    end
    // five good cycles of 112 core cycles needed with precision set
    send(rwd(1'b1, 2'h0));
    send(24'h000701);
    send(fwd(2'h3, 3'h1, 2'h0));
    at(420);
    check({2'h0, lock}, 3'h0, "lock before five cycles");
    at(280);
    check({2'h0, lock}, 3'h1, "lock after five cycles");
    check(cur, 3'h5, "pump current one");
    check({1'h0, mon_oe, mon}, 3'h3, "monitor digital lock");
    at(200);
    check({2'h0, lock}, 3'h1, "lock held");
    $display("test precise lock done");
    // ratio 57 with one swallow makes the phase drift every cycle
    send(24'h200705);
    at(300);
    check({2'h0, lock}, 3'h0, "lock after drift");
    check(cur, 3'h2, "pump current two");
    $display("test lock loss done");
    send(rwd(1'b0, 2'h3));
    send(24'h000701);
    send(fwd(2'h3, 3'h5, 2'h0)); // analog lock on the monitor
    at(300);
    check({2'h0, lock}, 3'h0, "lock before three cycles");
    at(200);
    check({2'h0, lock}, 3'h1, "lock after three cycles");
    $display("test normal lock done");
    i_sys_rst <= 1'b1;
    at(2);
    check({lock, powered, mon_oe}, 3'h0, "outputs in reset");
    i_sys_rst <= 1'b0;
    at(6);
    check({2'h0, mon_oe}, 3'h0, "monitor after second reset");
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
